// *** verilog/output_data_selector.sv ***
// output data selector: clock divider, key strobe, completion, source selection
`timescale 1ns/1ps
module output_data_selector
(
   input wire logic clock,
   input wire logic rst,
   input wire selector_pkg::ctrlPins_t ctrlPins,
   input wire selector_pkg::dataPins_t dataPins,
   output logic clockHalf,
   output logic clockQuarter,
   output logic keyStrobe,
   output logic funcDone,
   output logic outStrobe,
   output logic selHigh,
   output logic selLow,
   output selector_pkg::charBits_t outBits,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   // ==========================================================
   // pin synchronisers
   selector_pkg::ctrlPins_t ctrlMeta;
   selector_pkg::ctrlPins_t ctrlSync;
   selector_pkg::dataPins_t dataMeta;
   selector_pkg::dataPins_t dataSync;

   // all pins are asynchronous to clock, two stages each; control pins held at idle
   // levels, data pins at zero in reset so no unknown reaches the logic right after release
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         ctrlMeta <= selector_pkg::CTRL_PINS_IDLE;
         ctrlSync <= selector_pkg::CTRL_PINS_IDLE;
         dataMeta <= '0;
         dataSync <= '0;
      end
      else
      begin
         ctrlMeta <= ctrlPins;
         ctrlSync <= ctrlMeta;
         dataMeta <= dataPins;
         dataSync <= dataMeta;
      end
   end

   // ==========================================================
   // clock divider
   logic [selector_pkg::TICK_W-1:0] tickCount;
   logic tick;
   logic fall1M;

   // one tick per 4 MHz master period
   always_ff @(posedge clock)
   begin
      if (rst)
         tickCount <= '0;
      else if (tickCount == selector_pkg::TICK_LAST)
         tickCount <= '0;
      else
         tickCount <= tickCount + 1'b1;
   end

   assign tick = (tickCount == selector_pkg::TICK_LAST);
   // 1 MHz falls when both divided clocks are high at a tick
   assign fall1M = tick && clockHalf && clockQuarter;

   // divided clocks are flops, used in logic only as enables
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         clockHalf <= 1'b0;
         clockQuarter <= 1'b0;
      end
      else if (tick)
      begin
         clockHalf <= !clockHalf;
         if (clockHalf)
            clockQuarter <= !clockQuarter;
      end
   end

   a_half_ratio: assert property (@(posedge clock) disable iff (rst)
      $changed(clockQuarter) |-> $changed(clockHalf) && !clockHalf)
      else $error("1 MHz clock moved off a 2 MHz fall");

   a_half_period: assert property (@(posedge clock) disable iff (rst)
      $changed(clockHalf) |-> $past(tick))
      else $error("2 MHz clock moved off a master tick");

   // ==========================================================
   // completion logic
   logic doneAny;
   logic funcAny;

   assign doneAny = !(&ctrlSync.doneN);
   assign funcAny = !(&(ctrlSync.doneN | (selector_pkg::DONE_COUNT)'(1)
      << selector_pkg::XMIT_DONE_IDX));

   always_ff @(posedge clock)
   begin
      if (rst)
         funcDone <= 1'b0;
      else
         funcDone <= funcAny;
   end

   a_xmit_silent: assert property (@(posedge clock) disable iff (rst)
      (ctrlSync.doneN == ~((selector_pkg::DONE_COUNT)'(1) << selector_pkg::XMIT_DONE_IDX))
      |=> !funcDone)
      else $error("transmit done alone raised function done");

   // ==========================================================
   // keyboard strobe sequencer
   selector_pkg::strobeState_t state;
   selector_pkg::strobeState_t next_state;
   logic rawPrev;
   logic rawRise;
   logic armed;
   logic lockout;

   always_ff @(posedge clock)
   begin
      if (rst)
         rawPrev <= 1'b0;
      else
         rawPrev <= ctrlSync.rawKeyStrobe;
   end

   assign rawRise = ctrlSync.rawKeyStrobe && !rawPrev;

   // lock is held through the strobe's last period, so a clear then is lost
   always_comb
   begin
      next_state = state;
      case (state)
         selector_pkg::ST_IDLE:
            if (rawRise)
               next_state = selector_pkg::ST_ARMED;
         selector_pkg::ST_ARMED:
            if (fall1M)
               next_state = selector_pkg::ST_PULSE;
         selector_pkg::ST_PULSE:
            if (fall1M)
               next_state = selector_pkg::ST_HOLD;
         selector_pkg::ST_HOLD:
            if (fall1M)
               next_state = selector_pkg::ST_LOCKED;
         selector_pkg::ST_LOCKED:
            if (doneAny)
               next_state = selector_pkg::ST_IDLE;
         default:
            next_state = selector_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state <= selector_pkg::ST_IDLE;
         keyStrobe <= 1'b0;
      end
      else
      begin
         state <= next_state;
         keyStrobe <= (next_state == selector_pkg::ST_PULSE)
            || (next_state == selector_pkg::ST_HOLD);
      end
   end

   assign armed = (state == selector_pkg::ST_ARMED) || (state == selector_pkg::ST_PULSE);
   assign lockout = (state == selector_pkg::ST_HOLD) || (state == selector_pkg::ST_LOCKED);

   // helper: length of the current strobe in cycles
   logic [15:0] strobeLen;
   // strobe stands from the first to the third 1 MHz fall
   localparam int STROBE_CYC = 2 * selector_pkg::PERIOD_1M_CYC;

   always_ff @(posedge clock)
   begin
      if (rst || !keyStrobe)
         strobeLen <= '0;
      else
         strobeLen <= strobeLen + 16'h0001;
   end

   a_strobe_length: assert property (@(posedge clock) disable iff (rst)
      $fell(keyStrobe) |-> $past(strobeLen) == 16'(STROBE_CYC - 1))
      else $error("key strobe not two 1 MHz periods long");

   a_lock_no_arm: assert property (@(posedge clock) disable iff (rst)
      lockout |-> !armed)
      else $error("arming flag set under lockout");

   a_lock_blocks: assert property (@(posedge clock) disable iff (rst)
      $rose(keyStrobe) |-> $past(armed) && !$past(lockout))
      else $error("key strobe rose without arming or under lockout");

   a_done_release: assert property (@(posedge clock) disable iff (rst)
      (state == selector_pkg::ST_LOCKED) && doneAny |=> !lockout)
      else $error("completion did not clear lockout");

   // ==========================================================
   // source selection
   logic kbAuxEnable;
   logic ttyMode;
   logic kbPath;
   logic auxPath;
   selector_pkg::select_t sel;
   selector_pkg::charBits_t keyMasked;

   // delete (all ones) or closing bracket: bits 1, 3, 4, 5 high
   function automatic logic passChar(input selector_pkg::charBits_t c);
      passChar = c[0] && c[2] && c[3] && c[4];
   endfunction : passChar

   // path enables, pad send wins over both others
   assign kbPath = !ctrlSync.padSend && kbAuxEnable
      && (armed || keyStrobe);
   assign auxPath = !ctrlSync.padSend && !ctrlSync.auxSelectN
      && ctrlSync.auxStrobe && !kbPath;

   always_comb
   begin
      if (ctrlSync.padSend)
         sel = selector_pkg::SEL_PAD;
      else if (kbPath)
         sel = selector_pkg::SEL_KEY;
      else if (auxPath)
         sel = selector_pkg::SEL_AUX;
      else
         sel = selector_pkg::SEL_NONE;
   end

   // bit 6 masking only touches keyboard data, as on the selector input
   always_comb
   begin
      keyMasked = dataSync.key;
      if (ttyMode && dataSync.key[selector_pkg::BIT7_IDX] && !passChar(dataSync.key))
         keyMasked[selector_pkg::BIT6_IDX] = 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         selHigh <= 1'b1;
         selLow <= 1'b1;
         outBits <= '0;
         outStrobe <= 1'b0;
      end
      else
      begin
         {selHigh, selLow} <= sel;
         case (sel)
            selector_pkg::SEL_PAD: outBits <= dataSync.pad;
            selector_pkg::SEL_KEY: outBits <= keyMasked;
            selector_pkg::SEL_AUX: outBits <= dataSync.aux;
            default: outBits <= '0;
         endcase
         outStrobe <= (kbPath && keyStrobe) || auxPath
            || (ctrlSync.padSend && !ctrlSync.padXmitStrobeN);
      end
   end

   a_pad_wins: assert property (@(posedge clock) disable iff (rst)
      ctrlSync.padSend |=> !selHigh && !selLow && outBits == $past(dataSync.pad))
      else $error("pad send did not route scratch pad data");

   a_single_source: assert property (@(posedge clock) disable iff (rst)
      !(kbPath && auxPath) && !(ctrlSync.padSend && (kbPath || auxPath)))
      else $error("more than one data source enabled");

   a_bit6_mask: assert property (@(posedge clock) disable iff (rst)
      sel == selector_pkg::SEL_KEY && ttyMode && dataSync.key[selector_pkg::BIT7_IDX]
      && !passChar(dataSync.key) |=> !outBits[selector_pkg::BIT6_IDX])
      else $error("bit 6 not masked in teleprinter mode");

   a_pad_strobe: assert property (@(posedge clock) disable iff (rst)
      ctrlSync.padSend && !ctrlSync.padXmitStrobeN |=> outStrobe)
      else $error("pad transmit strobe gave no data strobe");

   // ==========================================================
   // bus slave, one wait state per access
   logic access;
   logic [1:0] ctrlReg;

   assign access = psel && penable && !pready;
   assign ttyMode = ctrlReg[selector_pkg::CTRL_TTY_BIT];
   assign kbAuxEnable = ctrlReg[selector_pkg::CTRL_KBAUX_BIT];

   // control register steers mode and keyboard/aux enable;
   // a write lands at the edge that completes the transfer
   always_ff @(posedge clock)
   begin
      if (rst)
         ctrlReg <= selector_pkg::CTRL_RESET;
      else if (psel && penable && pready && pwrite && paddr == selector_pkg::CTRL_ADDR)
         ctrlReg <= pwdata[1:0];
   end

   // status reads live sequencer state and outputs
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end
      else
      begin
         pready <= access;
         pslverr <= access && paddr != selector_pkg::CTRL_ADDR
            && paddr != selector_pkg::STATUS_ADDR;
         prdata <= '0;
         if (access && !pwrite)
         begin
            if (paddr == selector_pkg::CTRL_ADDR)
               prdata <= {30'h0, ctrlReg};
            else if (paddr == selector_pkg::STATUS_ADDR)
               prdata <= {20'h0, funcDone, outStrobe, selHigh, selLow,
                  lockout, armed, keyStrobe, state};
         end
      end
   end

   a_bus_answer: assert property (@(posedge clock) disable iff (rst)
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("bus answer not one cycle after access");
endmodule : output_data_selector

// *** pkg/selector_pkg.sv ***
// constants, encodings and carriers for the output data selector
package selector_pkg;
   // ==========================================================
   // timing
   localparam int unsigned CLOCK_HZ = 200_000_000;
   localparam int unsigned MASTER_HZ = 4_000_000;
   // cycles of the system clock per 4 MHz master period
   localparam int unsigned TICK_CYC = CLOCK_HZ / MASTER_HZ;
   // cycles per 1 MHz period, four master periods
   localparam int unsigned PERIOD_1M_CYC = 4 * TICK_CYC;
   localparam int unsigned TICK_W = $clog2(TICK_CYC);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

   // ==========================================================
   // register map, byte addresses on the bus
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam int CTRL_TTY_BIT = 0;
   localparam int CTRL_KBAUX_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // ==========================================================
   // completion inputs
   localparam int DONE_COUNT = 6;
   localparam int XMIT_DONE_IDX = 0;

   // ==========================================================
   // character decode, 7-bit codes with bit 1 at index 0
   localparam int CHAR_W = 7;
   localparam int BIT6_IDX = 5;
   localparam int BIT7_IDX = 6;
   typedef logic [CHAR_W-1:0] charBits_t;

   // selector codes {high select, low select}
   typedef enum logic [1:0] {
      SEL_PAD = 2'h0,
      SEL_KEY = 2'h1,
      SEL_AUX = 2'h2,
      SEL_NONE = 2'h3
   } select_t;

   // keyboard strobe sequencer, one-hot
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_ARMED = 5'h02,
      ST_PULSE = 5'h04,
      ST_HOLD = 5'h08,
      ST_LOCKED = 5'h10
   } strobeState_t;

   // control pins from the terminal side
   typedef struct packed {
      logic rawKeyStrobe;
      logic auxStrobe;
      logic auxSelectN;
      logic padSend;
      logic padXmitStrobeN;
      logic [DONE_COUNT-1:0] doneN;
   } ctrlPins_t;

   // pin levels the synchronisers take in reset: nothing struck, nothing done
   localparam ctrlPins_t CTRL_PINS_IDLE = '{rawKeyStrobe: 1'h0, auxStrobe: 1'h0,
      auxSelectN: 1'h1, padSend: 1'h0, padXmitStrobeN: 1'h1, doneN: '1};

   // the three data sources
   typedef struct packed {
      charBits_t pad;
      charBits_t key;
      charBits_t aux;
   } dataPins_t;
endpackage : selector_pkg

// *** tb/far_side_model.sv ***
// far-side model: keyboard, aux source, scratch pad and completion lines
`timescale 1ns/1ps
module far_side_model
#(
   parameter selector_pkg::charBits_t AUX_CODE = 7'h2a,
   parameter selector_pkg::charBits_t PAD_CODE = 7'h55
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic keyHit,
   input wire selector_pkg::charBits_t keyCode,
   input wire logic auxHit,
   input wire logic auxSelN,
   input wire logic padOn,
   input wire logic padXmit,
   input wire logic doneAuto,
   input wire logic doneNow,
   input wire logic [2:0] doneIdx,
   input wire logic [7:0] doneDelay,
   input wire logic keyStrobe,
   output selector_pkg::ctrlPins_t ctrlPins,
   output selector_pkg::dataPins_t dataPins
);
   logic lastStrobe;
   logic [8:0] doneCnt;
   // ==========
   // pins; idle data lines show the inverse code so stale data never matches
   always_ff @(posedge clock)
   begin
      ctrlPins.rawKeyStrobe <= keyHit;
      ctrlPins.auxStrobe <= auxHit;
      ctrlPins.auxSelectN <= auxSelN;
      ctrlPins.padSend <= padOn;
      ctrlPins.padXmitStrobeN <= !padXmit;
      dataPins.key <= keyHit ? keyCode : ~keyCode;
      dataPins.aux <= auxHit ? AUX_CODE : ~AUX_CODE;
      dataPins.pad <= padOn ? PAD_CODE : ~PAD_CODE;
      for (int i = 0; i < 6; i++)
         ctrlPins.doneN[i] <= !(doneCnt != 9'h000 && doneCnt <= 9'h004 && doneIdx == 3'(i));
   end
   // completion answers a set delay after the strobe ends, low four cycles
   always_ff @(posedge clock)
   begin
      lastStrobe <= keyStrobe;
      if (rst)
         doneCnt <= 9'h000;
      else if ((doneAuto && lastStrobe && !keyStrobe) || doneNow)
         doneCnt <= {1'h0, doneDelay} + 9'h004;
      else if (doneCnt != 9'h000)
         doneCnt <= doneCnt - 9'h001;
   end
endmodule : far_side_model

// *** tb/output_data_selector_test.sv ***
// self-checking bench for the output data selector
`timescale 1ns/1ps
module output_data_selector_test;
   localparam selector_pkg::charBits_t AUX_CODE = 7'h2a;
   localparam selector_pkg::charBits_t PAD_CODE = 7'h55;
   typedef struct {logic teleprinter_mode; logic [6:0] code; logic [6:0] want;} row_t;
   // teleprinter off, masked letter, DEL, bracket, bit 7 low, masked tilde
   row_t rows [6] = '{'{1'h0, 7'h61, 7'h61}, '{1'h1, 7'h61, 7'h41}, '{1'h1, 7'h7f, 7'h7f},
      '{1'h1, 7'h5d, 7'h5d}, '{1'h1, 7'h3f, 7'h3f}, '{1'h1, 7'h7e, 7'h5e}};
   logic clock = 1'h0;
   logic rst = 1'h1;
   selector_pkg::ctrlPins_t ctrlPins;
   selector_pkg::dataPins_t dataPins;
   logic clockHalf, clockQuarter, keyStrobe, funcDone, outStrobe, selHigh, selLow;
   selector_pkg::charBits_t outBits;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err;
   logic keyHit = 1'h0, auxHit = 1'h0, auxSelN = 1'h1, padOn = 1'h0, padXmit = 1'h0;
   logic doneAuto = 1'h1, doneNow = 1'h0;
   logic [2:0] doneIdx = 3'h0;
   logic [7:0] doneDelay = 8'h04;
   selector_pkg::charBits_t keyCode = 7'h00;
   int nFail = 0, testsRun = 0, n, i;

   always #2.5 clock = ~clock;

   output_data_selector u_output_data_selector (.clock(clock), .rst(rst),
      .ctrlPins(ctrlPins), .dataPins(dataPins), .clockHalf(clockHalf),
      .clockQuarter(clockQuarter), .keyStrobe(keyStrobe), .funcDone(funcDone),
      .outStrobe(outStrobe), .selHigh(selHigh), .selLow(selLow), .outBits(outBits),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   far_side_model #(.AUX_CODE(AUX_CODE), .PAD_CODE(PAD_CODE)) u_far_side_model (
      .clock(clock), .rst(rst), .keyHit(keyHit), .keyCode(keyCode), .auxHit(auxHit),
      .auxSelN(auxSelN), .padOn(padOn), .padXmit(padXmit), .doneAuto(doneAuto),
      .doneNow(doneNow), .doneIdx(doneIdx), .doneDelay(doneDelay),
      .keyStrobe(keyStrobe), .ctrlPins(ctrlPins), .dataPins(dataPins));

   // ==========
   // reporting
   task stopTest;
      begin
         $display("checks %0d mismatches %0d", testsRun, nFail);
         if (nFail == 0 && testsRun > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask : stopTest

   task check(input logic ok, input string msg);
      begin
         testsRun++;
         if (ok !== 1'h1)
         begin
            nFail++;
            $display("mismatch at %0t: %s", $time, msg);
         end
      end
   endtask : check

   // bounded wait for a level, counting edges
   task automatic waitSig(ref logic s, input logic v, output int k);
      begin
         k = 0;
         while (s !== v && k < 1000)
         begin
            @(posedge clock);
            k++;
         end
         if (k >= 1000)
         begin
            check(1'h0, "wait timeout");
            stopTest;
         end
      end
   endtask : waitSig

   // one apb transfer; an idle edge after it so strobes never double up
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int k;
      begin
         psel <= 1'h1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge clock);
         penable <= 1'h1;
         k = 0;
         do
         begin
            @(posedge clock);
            k++;
         end
         while (pready !== 1'h1 && k < 50);
         r = prdata;
         e = pslverr;
         psel <= 1'h0;
         penable <= 1'h0;
         if (k >= 50)
         begin
            check(1'h0, "bus timeout");
            stopTest;
         end
         @(posedge clock);
      end
   endtask : apb

   // ==========
   // main sequence
   initial
   begin
      repeat (2) @(posedge clock);
      rst <= 1'h0;
      @(posedge clock);
      check({selHigh, selLow, outBits, keyStrobe, funcDone} === 11'h600, "reset outputs");
      apb(1'h0, selector_pkg::CTRL_ADDR, 32'h0, rd, err);
      check(rd === 32'h0 && err === 1'h0, "control reset value");
      apb(1'h0, 8'h08, 32'h0, rd, err);
      check(err === 1'h1 && rd === 32'h0, "unmapped read");
      waitSig(clockHalf, 1'h1, n);
      waitSig(clockHalf, 1'h0, n);
      check(n == 50, "2 MHz high time");
      waitSig(clockHalf, 1'h1, n);
      check(n == 50, "2 MHz low time");
      waitSig(clockQuarter, 1'h0, n);
      waitSig(clockQuarter, 1'h1, n);
      check(n == 100, "1 MHz low time");
      for (i = 0; i < 6; i++)
      begin
         apb(1'h1, selector_pkg::CTRL_ADDR, {30'h0, 1'h1, rows[i].teleprinter_mode}, rd, err);
         doneIdx <= 3'(i);
         doneDelay <= 8'(i * 8 + 4);
         keyCode <= rows[i].code;
         keyHit <= 1'h1;
         waitSig(keyStrobe, 1'h1, n);
         check(clockQuarter === 1'h0, "strobe off a 1 MHz fall");
         repeat (2) @(posedge clock);
         check({selHigh, selLow} === 2'h1 && outStrobe === 1'h1, "key path");
         check(outBits === rows[i].want, "bit 6 mask");
         waitSig(keyStrobe, 1'h0, n);
         check(n == 398, "key strobe width");
         keyHit <= 1'h0;
         n = 0;
         repeat (60)
         begin
            @(posedge clock);
            if (funcDone === 1'h1)
               n++;
         end
         check((n > 0) == (i != 0), "function done");
      end
      // lockout holds with no completion
      doneAuto <= 1'h0;
      keyHit <= 1'h1;
      waitSig(keyStrobe, 1'h1, n);
      waitSig(keyStrobe, 1'h0, n);
      keyHit <= 1'h0;
      repeat (8) @(posedge clock);
      keyHit <= 1'h1;
      n = 0;
      repeat (600)
      begin
         @(posedge clock);
         if (keyStrobe === 1'h1)
            n++;
      end
      check(n == 0, "strobe while locked");
      apb(1'h0, selector_pkg::STATUS_ADDR, 32'h0, rd, err);
      check(rd[7] === 1'h1, "lock flag");
      doneIdx <= 3'h0;
      doneDelay <= 8'h04;
      doneNow <= 1'h1;
      @(posedge clock);
      doneNow <= 1'h0;
      repeat (20) @(posedge clock);
      apb(1'h0, selector_pkg::STATUS_ADDR, 32'h0, rd, err);
      check(rd[7] === 1'h0 && rd[4:0] === 5'h01, "unlocked by transmit done");
      keyHit <= 1'h0;
      repeat (8) @(posedge clock);
      // keyboard path switched off: a strobe still runs but selects nothing
      apb(1'h1, selector_pkg::CTRL_ADDR, 32'h0, rd, err);
      keyHit <= 1'h1;
      waitSig(keyStrobe, 1'h1, n);
      repeat (2) @(posedge clock);
      check({selHigh, selLow, outStrobe} === 3'h6, "key path disabled");
      waitSig(keyStrobe, 1'h0, n);
      keyHit <= 1'h0;
      // auxiliary, then scratch pad overriding it
      auxSelN <= 1'h0;
      auxHit <= 1'h1;
      repeat (8) @(posedge clock);
      check({selHigh, selLow} === 2'h2 && outBits === AUX_CODE, "aux path");
      check(outStrobe === 1'h1, "aux data strobe");
      padOn <= 1'h1;
      repeat (8) @(posedge clock);
      check({selHigh, selLow} === 2'h0 && outBits === PAD_CODE, "pad priority");
      check(outStrobe === 1'h0, "pad strobe idle");
      padXmit <= 1'h1;
      repeat (8) @(posedge clock);
      check(outStrobe === 1'h1, "pad data strobe");
      padOn <= 1'h0;
      padXmit <= 1'h0;
      auxSelN <= 1'h1;
      repeat (8) @(posedge clock);
      check({selHigh, selLow, outStrobe} === 3'h6, "no source");
      stopTest;
   end
endmodule : output_data_selector_test
